// File: rtl/rtc_core.sv
// Clock/calendar core with serial register access and square-wave output
// Overview of operation
// - Clock at 00h-07h, RAM at 08h-3Fh
// - Pointer wraps from 3Fh to 00h
// - Time and calendar held in BCD
// - Weekday advances at midnight, cycles 1-7
// - Seconds bit 7 halts oscillator and counting
// - Power-on date 01/01/00 day 01, halted
// - Hours bit 6 selects 12 or 24 hour
// - Bit 5 is PM or twenties digit
// - START copies counters into read buffers
// - Seconds write restarts sub-second divider
// - Written bytes commit at our acknowledge
// - Fixed-zero bits always read zero
// - Disabled square wave drives static level bit
// - Enable bit drives square wave from oscillator
// - Rate bits pick 1Hz, 4k, 8k, 32k
// - 1Hz output falls as registers update
// - Control powers up with rates set, rest clear
// - Read without pointer load uses stored pointer
// - Power fail aborts access, clears pointer
`timescale 1ns/1ps
module rtc_core
    import rtc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic osc_clk,
    input  wire logic power_fail,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      square_wave_pin_out,
    output logic      square_wave_pin_oe
);
    logic [7:0]       seconds_count, minutes_count, hours_count, weekday_count;
    logic [7:0]       date_count, month_count, year_count, output_control;
    logic [7:0]       next_seconds, next_minutes, next_hours, next_weekday;
    logic [7:0]       next_date, next_month, next_year;
    logic [7:0]       shadow [0:6];
    logic [2:0]       osc_sync, scl_sync, sda_sync, pf_sync;
    logic             osc_rise, running, tick;
    logic [DIV_W-1:0] sub_div;
    logic             scl_rise, scl_fall, bus_start, bus_stop;
    rtc_state_type    state;
    rtc_kind_type     kind;
    logic [2:0]       bit_cnt;
    logic             byte_full, read_mode, master_ack;
    logic [7:0]       shift;
    logic [PTR_W-1:0] ptr;
    logic             wr_en, ram_wr;
    logic [7:0]       ram_q, rd_byte, dim;
    logic             square_level;

    rtc_ram #(.WIDTH(8), .ADDR_W(PTR_W)) u_ram (
        .ref_clk (ref_clk),
        .wr_en   (ram_wr),
        .addr    (ptr),
        .wr_data (shift),
        .rd_data (ram_q)
    );

    // Pins from outside pass three flops; stages 2 and 3 feed the edge detectors
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            osc_sync <= 3'h0;
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            pf_sync  <= 3'h0;
        end else begin
            osc_sync <= {osc_sync[1:0], osc_clk};
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            pf_sync  <= {pf_sync[1:0], power_fail};
        end
    end

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    assign osc_rise  = osc_sync[1] & ~osc_sync[2];
    assign running   = ~seconds_count[BIT_HALT];
    assign tick      = running & osc_rise & (sub_div == DIV_LAST);
    assign scl_rise  = scl_sync[1] & ~scl_sync[2];
    assign scl_fall  = ~scl_sync[1] & scl_sync[2];
    assign bus_start = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
    assign bus_stop  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];
    assign ram_wr    = wr_en & (ptr >= ADDR_RAM_LO);

    // Sub-second divider; its wrap is the 1 Hz falling edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sub_div <= '0;
        end else if (wr_en && ptr == ADDR_SECONDS) begin
            sub_div <= '0;
        end else if (running && osc_rise) begin
            sub_div <= sub_div + 1'b1;
        end
    end

    // Leap years fall on BCD years divisible by four; good to 2099
    always_comb begin
        dim = 8'h31;
        case (month_count[4:0])
            5'h04, 5'h06, 5'h09, 5'h11: dim = 8'h30;
            5'h02: begin
                if (year_count[4] ? (year_count[3:0] == 4'h2 || year_count[3:0] == 4'h6)
                                  : (year_count[1:0] == 2'h0)) begin
                    dim = 8'h29;
                end else begin
                    dim = 8'h28;
                end
            end
            default: dim = 8'h31;
        endcase
    end

    // Carry chain of one tick
    always_comb begin
        logic c_min, c_hr, c_day, c_mon, c_yr;
        c_min = 1'b0;
        c_hr  = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        c_yr  = 1'b0;
        next_seconds = {seconds_count[7], 7'h00} | (bcd_inc(seconds_count & 8'h7f) & 8'h7f);
        next_minutes = minutes_count;
        next_hours   = hours_count;
        next_weekday = weekday_count;
        next_date    = date_count;
        next_month   = month_count;
        next_year    = year_count;
        if ({1'b0, seconds_count[6:0]} == BCD_59) begin
            next_seconds = {seconds_count[7], 7'h00};
            c_min        = 1'b1;
        end
        if (c_min) begin
            next_minutes = bcd_inc(minutes_count);
            if (minutes_count == BCD_59) begin
                next_minutes = 8'h00;
                c_hr         = 1'b1;
            end
        end
        if (c_hr) begin
            if (hours_count[BIT_MODE12]) begin
                if ({3'h0, hours_count[4:0]} == BCD_12) begin
                    next_hours = {hours_count[7:5], BCD_01[4:0]};
                end else if ({3'h0, hours_count[4:0]} == BCD_11) begin
                    next_hours = {hours_count[7:6], ~hours_count[BIT_PM], BCD_12[4:0]};
                    c_day      = hours_count[BIT_PM];
                end else begin
                    next_hours = {hours_count[7:5], 5'h00}
                               | (bcd_inc(hours_count & 8'h1f) & 8'h1f);
                end
            end else if ({2'h0, hours_count[5:0]} == BCD_23) begin
                next_hours = {hours_count[7:6], 6'h00};
                c_day      = 1'b1;
            end else begin
                next_hours = {hours_count[7:6], 6'h00}
                           | (bcd_inc(hours_count & 8'h3f) & 8'h3f);
            end
        end
        if (c_day) begin
            next_weekday = (weekday_count == DAY_LAST) ? BCD_01 : weekday_count + 8'h01;
            next_date    = bcd_inc(date_count);
            if (date_count >= dim) begin
                next_date = BCD_01;
                c_mon     = 1'b1;
            end
        end
        if (c_mon) begin
            next_month = bcd_inc(month_count);
            if (month_count >= BCD_12) begin
                next_month = BCD_01;
                c_yr       = 1'b1;
            end
        end
        if (c_yr) begin
            next_year = (year_count == BCD_99) ? 8'h00 : bcd_inc(year_count);
        end
    end

    // Time registers; a bus write in the tick cycle wins
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            seconds_count  <= RST_SECONDS;
            minutes_count  <= RST_MINUTES;
            hours_count    <= RST_HOURS;
            weekday_count  <= RST_WEEKDAY;
            date_count     <= RST_DATE;
            month_count    <= RST_MONTH;
            year_count     <= RST_YEAR;
            output_control <= RST_CONTROL;
        end else if (wr_en && ptr < ADDR_RAM_LO) begin
            case (ptr)
                ADDR_SECONDS: seconds_count  <= shift & MASK_SECONDS;
                ADDR_MINUTES: minutes_count  <= shift & MASK_MINUTES;
                ADDR_HOURS:   hours_count    <= shift & MASK_HOURS;
                ADDR_WEEKDAY: weekday_count  <= shift & MASK_WEEKDAY;
                ADDR_DATE:    date_count     <= shift & MASK_DATE;
                ADDR_MONTH:   month_count    <= shift & MASK_MONTH;
                ADDR_YEAR:    year_count     <= shift & MASK_YEAR;
                default:      output_control <= shift & MASK_CONTROL;
            endcase
        end else if (tick) begin
            seconds_count <= next_seconds;
            minutes_count <= next_minutes;
            hours_count   <= next_hours;
            weekday_count <= next_weekday;
            date_count    <= next_date;
            month_count   <= next_month;
            year_count    <= next_year;
        end
    end

    // Read buffers freeze at START so a multibyte read sees one instant
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 7; i++) begin
                shadow[i] <= 8'h00;
            end
        end else if (bus_start && !pf_sync[2]) begin
            shadow[0] <= seconds_count;
            shadow[1] <= minutes_count;
            shadow[2] <= hours_count;
            shadow[3] <= weekday_count;
            shadow[4] <= date_count;
            shadow[5] <= month_count;
            shadow[6] <= year_count;
        end
    end

    always_comb begin
        if (ptr >= ADDR_RAM_LO) begin
            rd_byte = ram_q;
        end else if (ptr == ADDR_CONTROL) begin
            rd_byte = output_control;
        end else begin
            rd_byte = shadow[ptr[2:0]];
        end
    end

    // Serial slave; pointer wraps naturally at 6 bits
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state      <= st_idle;
            kind       <= kind_addr;
            bit_cnt    <= 3'h0;
            byte_full  <= 1'b0;
            read_mode  <= 1'b0;
            master_ack <= 1'b0;
            shift      <= 8'h00;
            ptr        <= '0;
            wr_en      <= 1'b0;
            sda_oe     <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            if (pf_sync[2]) begin
                state     <= st_idle;
                ptr       <= '0;
                sda_oe    <= 1'b0;
                byte_full <= 1'b0;
            end else if (bus_start) begin
                state     <= st_rx;
                kind      <= kind_addr;
                bit_cnt   <= 3'h0;
                byte_full <= 1'b0;
                sda_oe    <= 1'b0;
            end else if (bus_stop) begin
                state  <= st_idle;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    st_rx: begin
                        if (scl_rise) begin
                            shift     <= {shift[6:0], sda_sync[2]};
                            bit_cnt   <= bit_cnt + 3'h1;
                            byte_full <= (bit_cnt == 3'h7);
                        end else if (scl_fall && byte_full) begin
                            byte_full <= 1'b0;
                            state     <= st_ack;
                            sda_oe    <= 1'b1;
                            case (kind)
                                kind_addr: begin
                                    read_mode <= shift[0];
                                    if (shift[7:1] != BUS_ADDRESS) begin
                                        state  <= st_idle;
                                        sda_oe <= 1'b0;
                                    end
                                end
                                kind_ptr: ptr <= shift[PTR_W-1:0];
                                default: wr_en <= 1'b1;
                            endcase
                        end
                    end
                    st_ack: begin
                        if (wr_en) begin
                            ptr <= ptr + 1'b1;
                        end
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (kind == kind_addr && read_mode) begin
                                state  <= st_tx;
                                shift  <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                            end else begin
                                state  <= st_rx;
                                sda_oe <= 1'b0;
                                kind   <= (kind == kind_addr) ? kind_ptr : kind_data;
                            end
                        end
                    end
                    st_tx: begin
                        if (scl_fall) begin
                            if (bit_cnt == 3'h7) begin
                                state  <= st_mack;
                                sda_oe <= 1'b0;
                                ptr    <= ptr + 1'b1;
                            end else begin
                                bit_cnt <= bit_cnt + 3'h1;
                                shift   <= {shift[6:0], 1'b0};
                                sda_oe  <= ~shift[6];
                            end
                        end
                    end
                    st_mack: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_sync[2];
                        end else if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (master_ack) begin
                                state  <= st_tx;
                                shift  <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    default: state <= st_idle;
                endcase
            end
        end
    end

    assign sda_out             = 1'b0;
    assign square_wave_pin_out = 1'b0;

    // Output level; oscillator halt freezes every rate
    always_comb begin
        case (output_control[1:0])
            RATE_1HZ: square_level = sub_div[DIV_W-1];
            RATE_4K:  square_level = sub_div[DIV_4K_BIT];
            RATE_8K:  square_level = sub_div[DIV_8K_BIT];
            default:  square_level = osc_sync[2] & running;
        endcase
        if (!output_control[BIT_SQW_EN]) begin
            square_level = output_control[BIT_LEVEL];
        end
    end

    // Open drain: driving means pulling low
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            square_wave_pin_oe <= 1'b1;
        end else begin
            square_wave_pin_oe <= ~square_level;
        end
    end
endmodule : rtc_core

// File: rtl/rtc_pkg.sv
// Package with register map, field layout, reset values and bus constants of the clock core
package rtc_pkg;
    localparam int        PTR_W          = 6;
    localparam logic [5:0] ADDR_SECONDS  = 6'h00;
    localparam logic [5:0] ADDR_MINUTES  = 6'h01;
    localparam logic [5:0] ADDR_HOURS    = 6'h02;
    localparam logic [5:0] ADDR_WEEKDAY  = 6'h03;
    localparam logic [5:0] ADDR_DATE     = 6'h04;
    localparam logic [5:0] ADDR_MONTH    = 6'h05;
    localparam logic [5:0] ADDR_YEAR     = 6'h06;
    localparam logic [5:0] ADDR_CONTROL  = 6'h07;
    localparam logic [5:0] ADDR_RAM_LO   = 6'h08;
    localparam logic [5:0] ADDR_RAM_HI   = 6'h3f;
    localparam logic [6:0] BUS_ADDRESS   = 7'h68;
    // Writable bits; the rest read as zero
    localparam logic [7:0] MASK_SECONDS  = 8'hff;
    localparam logic [7:0] MASK_MINUTES  = 8'h7f;
    localparam logic [7:0] MASK_HOURS    = 8'h7f;
    localparam logic [7:0] MASK_WEEKDAY  = 8'h07;
    localparam logic [7:0] MASK_DATE     = 8'h3f;
    localparam logic [7:0] MASK_MONTH    = 8'h1f;
    localparam logic [7:0] MASK_YEAR     = 8'hff;
    localparam logic [7:0] MASK_CONTROL  = 8'h93;
    // Power-on values
    localparam logic [7:0] RST_SECONDS   = 8'h80;
    localparam logic [7:0] RST_MINUTES   = 8'h00;
    localparam logic [7:0] RST_HOURS     = 8'h00;
    localparam logic [7:0] RST_WEEKDAY   = 8'h01;
    localparam logic [7:0] RST_DATE      = 8'h01;
    localparam logic [7:0] RST_MONTH     = 8'h01;
    localparam logic [7:0] RST_YEAR      = 8'h00;
    localparam logic [7:0] RST_CONTROL   = 8'h03;
    // Field positions
    localparam int        BIT_HALT       = 7;
    localparam int        BIT_MODE12     = 6;
    localparam int        BIT_PM         = 5;
    localparam int        BIT_LEVEL      = 7;
    localparam int        BIT_SQW_EN     = 4;
    localparam logic [1:0] RATE_1HZ      = 2'h0;
    localparam logic [1:0] RATE_4K       = 2'h1;
    localparam logic [1:0] RATE_8K       = 2'h2;
    localparam logic [1:0] RATE_32K      = 2'h3;
    // Oscillator divider: 32768 Hz down to 1 Hz
    localparam int        OSC_HZ         = 32768;
    localparam int        DIV_W          = $clog2(OSC_HZ);
    localparam int        DIV_4K_BIT     = 2;
    localparam int        DIV_8K_BIT     = 1;
    localparam logic [14:0] DIV_LAST     = 15'h7fff;
    // BCD limits
    localparam logic [7:0] BCD_59        = 8'h59;
    localparam logic [7:0] BCD_23        = 8'h23;
    localparam logic [7:0] BCD_12        = 8'h12;
    localparam logic [7:0] BCD_11        = 8'h11;
    localparam logic [7:0] BCD_99        = 8'h99;
    localparam logic [7:0] BCD_01        = 8'h01;
    localparam logic [7:0] DAY_LAST      = 8'h07;

    typedef enum logic [4:0] {
        st_idle = 5'h01,
        st_rx   = 5'h02,
        st_ack  = 5'h04,
        st_tx   = 5'h08,
        st_mack = 5'h10
    } rtc_state_type;

    typedef enum logic [1:0] {
        kind_addr = 2'h0,
        kind_ptr  = 2'h1,
        kind_data = 2'h2
    } rtc_kind_type;
endpackage : rtc_pkg

// File: rtl/rtc_ram.sv
// General-purpose byte memory with registered read data
`timescale 1ns/1ps
module rtc_ram #(
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 6
) (
    input  wire logic              ref_clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    output logic      [WIDTH-1:0]  rd_data
);
    logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

    if (ADDR_W < 6 || WIDTH < 1) begin : g_check
        $error("rtc_ram needs at least 64 entries");
    end

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_data <= mem[addr];
    end
endmodule : rtc_ram

// File: testbench/rtc_core_sva.sv
// Port checker for the clock core serial bus and square-wave pin
`timescale 1ns/1ps
module rtc_core_sva (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic osc_clk,
    input  wire logic power_fail,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic sda_out,
    input  wire logic sda_oe,
    input  wire logic square_wave_pin_out,
    input  wire logic square_wave_pin_oe
);
    logic       scl_q;
    logic [6:0] hold_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge ref_clk) begin
        scl_q <= scl_in;
    end
    // A drive that outlives all bus clock movement would hang the bus
    always_ff @(posedge ref_clk) begin
        if (!rstn || !sda_oe || scl_in != scl_q) begin
            hold_cnt <= 7'h00;
        end else if (hold_cnt != 7'h7f) begin
            hold_cnt <= hold_cnt + 7'h01;
        end
    end
    chk_reset_pin_low: assert property ($rose(rstn) |-> square_wave_pin_oe && !sda_oe)
        else $error("pin or bus not at reset level");
    chk_fail_bus_free: assert property (power_fail [*5] |-> !sda_oe)
        else $error("bus driven during power fail");
    chk_ack_rise_low: assert property ($rose(sda_oe) |-> !$past(scl_in))
        else $error("data drive began with clock high");
    chk_drive_fall_low: assert property ($fell(sda_oe) |-> !$past(scl_in))
        else $error("data drive ended with clock high");
    chk_drive_stable_high: assert property (
        scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
        else $error("data drive moved while clock high");
    chk_drive_hold_bound: assert property (hold_cnt < 7'h28)
        else $error("data drive held without clock");
    chk_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    chk_pin_open_drain: assert property (square_wave_pin_out == 1'b0)
        else $error("square pin driven high");
endmodule : rtc_core_sva

bind rtc_core rtc_core_sva u_sva (
    .ref_clk             (ref_clk),
    .rstn                (rstn),
    .osc_clk             (osc_clk),
    .power_fail          (power_fail),
    .scl_in              (scl_in),
    .sda_in              (sda_in),
    .sda_out             (sda_out),
    .sda_oe              (sda_oe),
    .square_wave_pin_out (square_wave_pin_out),
    .square_wave_pin_oe  (square_wave_pin_oe)
);

// File: testbench/rtc_i2c_master.sv
// Bus master model that frames bytes on the two-wire register bus
`timescale 1ns/1ps
module rtc_i2c_master (
    input  wire logic ref_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_pull
);
    // Idle bus: clock stands high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : w
    // Data moves only mid-way through the low phase, never near a clock edge
    task automatic bit_io(input logic b, output logic r);
        w(2);
        sda_pull = !b;
        w(2);
        scl = 1'b1;
        w(4);
        r = sda_wire;
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        w(2);
        sda_pull = 1'b0;
        w(2);
        scl = 1'b1;
        w(4);
        sda_pull = 1'b1;
        w(4);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        w(2);
        sda_pull = 1'b1;
        w(2);
        scl = 1'b1;
        w(4);
        sda_pull = 1'b0;
        w(4);
    endtask : stop
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic nine);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(last, nine);
    endtask : xfer
endmodule : rtc_i2c_master

// File: testbench/rtc_core_bench.sv
// Self-checking bench for the clock core over its serial bus and square-wave pin
`timescale 1ns/1ps
module rtc_core_bench
    import rtc_pkg::*;
;
    logic        ref_clk    = 1'b0;
    logic        rstn       = 1'b0;
    logic        osc_clk    = 1'b0;
    logic        power_fail = 1'b0;
    logic        scl;
    logic        sda_pull;
    logic        sda_oe;
    logic        sq_oe;
    logic [7:0]  rx;
    logic        nine;
    logic [5:0]  ra;
    logic [7:0]  rw;
    logic [7:0]  re;
    int          failures   = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          n;
    logic [7:0]  rst_exp [8] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
    int          rate_exp [4] = '{0, 8, 16, 64};
    // Pointer, byte written, byte read back
    logic [21:0] rows [9] = '{{6'h01, 8'hff, 8'h7f}, {6'h02, 8'h72, 8'h72},
        {6'h03, 8'hff, 8'h07}, {6'h04, 8'hff, 8'h3f}, {6'h05, 8'hff, 8'h1f},
        {6'h06, 8'h99, 8'h99}, {6'h07, 8'hff, 8'h93}, {6'h08, 8'ha5, 8'ha5},
        {6'h3f, 8'h5a, 8'h5a}};
    always #12.5 ref_clk = ~ref_clk;
    always #100 osc_clk = ~osc_clk;
    rtc_i2c_master u_master (
        .ref_clk  (ref_clk),
        .sda_wire (!(sda_oe | sda_pull)),
        .scl      (scl),
        .sda_pull (sda_pull)
    );
    rtc_core u_dut (
        .ref_clk             (ref_clk),
        .rstn                (rstn),
        .osc_clk             (osc_clk),
        .power_fail          (power_fail),
        .scl_in              (scl),
        .sda_in              (!(sda_oe | sda_pull)),
        .sda_out             (),
        .sda_oe              (sda_oe),
        .square_wave_pin_out (),
        .square_wave_pin_oe  (sq_oe)
    );
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            results();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic put(input logic [7:0] b);
        u_master.xfer(b, 1'b1, rx, nine);
        check("ack", 8'h00, {7'h00, nine});
    endtask : put
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_master.start();
        put({BUS_ADDRESS, 1'b0});
        put({2'h0, a});
        put(d);
        u_master.stop();
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic load);
        if (load) begin
            u_master.start();
            put({BUS_ADDRESS, 1'b0});
            put({2'h0, a});
        end
        u_master.start();
        put({BUS_ADDRESS, 1'b1});
        u_master.xfer(8'hff, 1'b1, rx, nine);
        u_master.stop();
    endtask : rd
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge ref_clk);
        u_master.start();
        put({BUS_ADDRESS, 1'b1});
        for (int i = 0; i < 8; i++) begin
            u_master.xfer(8'hff, i == 7, rx, nine);
            check("reset map", rst_exp[i], rx);
        end
        u_master.stop();
        // Hours row rewrites the value along with its format bit
        for (int i = 0; i < 9; i++) begin
            {ra, rw, re} = rows[i];
            wr(ra, rw);
            rd(ra, 1'b1);
            check("row", re, rx);
        end
        u_master.start();
        put({BUS_ADDRESS, 1'b0});
        put(8'h3f);
        put(8'h11);
        put(8'h85);
        u_master.stop();
        rd(6'h00, 1'b1);
        check("wrapped write", 8'h85, rx);
        rd(6'h00, 1'b0);
        check("stored pointer", 8'h7f, rx);
        u_master.start();
        put({BUS_ADDRESS, 1'b0});
        put(8'h05);
        power_fail = 1'b1;
        u_master.w(10);
        u_master.xfer(8'h12, 1'b1, rx, nine);
        check("fail ack", 8'h01, {7'h00, nine});
        power_fail = 1'b0;
        u_master.w(10);
        u_master.stop();
        rd(6'h00, 1'b0);
        check("fail pointer", 8'h85, rx);
        rd(6'h05, 1'b1);
        check("fail write", 8'h1f, rx);
        wr(6'h07, 8'h80);
        check("level high", 8'h01, {7'h00, !sq_oe});
        wr(6'h07, 8'h00);
        check("level low", 8'h00, {7'h00, !sq_oe});
        // A foreign slave address must go unanswered
        u_master.start();
        u_master.xfer({BUS_ADDRESS ^ 7'h01, 1'b0}, 1'b1, rx, nine);
        check("foreign ack", 8'h01, {7'h00, nine});
        u_master.stop();
        // Running clock and all four rates, then halted at the fastest
        wr(6'h00, 8'h00);
        for (int r = 0; r < 5; r++) begin
            if (r == 4) begin
                wr(6'h00, 8'h80);
            end
            wr(6'h07, 8'h10 | r[1:0] | {6'h00, r[2], r[2]});
            n = 0;
            repeat (512) begin
                re[0] = sq_oe;
                u_master.w(1);
                n += int'(re[0] === 1'b0 && sq_oe === 1'b1);
            end
            rw[0] = n + 1 >= (r == 4 ? 0 : rate_exp[r]) && n <= (r == 4 ? 0 : rate_exp[r] + 1);
            check("rate", 8'h01, {7'h00, rw[0]});
        end
        results();
    end
endmodule : rtc_core_bench
